// ==== verilog/nv_eeprom_pkg.sv ====
// constants, types and field layout for the data eeprom access block
// assumes one core clock and a cpu that drives the i/o strobes synchronously
// Overview of operation
// R01: 512 byte array, 9-bit linear byte address 0 to 511, byte access.
// R02: a read halts the cpu for four clock cycles.
// R03: a write launch halts the cpu for two clock cycles.
// R04: address bits 15 to 9 read zero and ignore writes.
// R05: address is undefined after reset; software loads it before access.
// R06: write stores the data byte at the held address.
// R07: read places the byte at the held address into the data byte.
// R08: busy flag at bit 7 sets at program start, holds until done.
// R09: page-access bit 6 set by software, holds until program finishes.
// R10: page-access bit also clears on a flush.
// R11: page-access writes are ignored while the program strobe is one.
// R12: mode field at bits 5..4 selects the launched action.
// R13: mode field writes are ignored while the write strobe is set.
// R14: reset clears the mode field unless programming is in progress.
// R15: mode 00 erases then writes, about 3.4 ms.
// R16: mode 01 erases only, mode 10 writes only, about 1.8 ms each.
// R17: mode 11 programs nothing and discards the page buffer.
// R18: writes are self-timed and completion is reported.
// R19: software must arm then strobe; no write starts otherwise.
// R20: arm bit self-clears after four cycles; strobe counts only while armed.
// R21: write strobe self-clears when the write time has elapsed.
// R22: read strobe with valid address gives data immediately.
// R23: ready interrupt requested while enabled and the write strobe is clear.
// R24: per-mode cycle counter times programs; busy and strobe clear together.
package nv_eeprom_pkg;
  // ==========================================================================
  // array and register layout
  localparam int ADDR_W = 9;
  localparam int ARRAY_BYTES = 512;
  localparam int PAGE_BYTES = 4;
  localparam int PAGE_W = 2;
  localparam logic [1:0] SEL_ADDR_LOW = 2'h0;
  localparam logic [1:0] SEL_ADDR_HIGH = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;
  localparam logic [1:0] SEL_CONTROL = 2'h3;
  localparam int BIT_BUSY = 7;
  localparam int BIT_PAGE = 6;
  localparam int BIT_MODE_HI = 5;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_RIE = 3;
  localparam int BIT_ARM = 2;
  localparam int BIT_WSTROBE = 1;
  localparam int BIT_RSTROBE = 0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ==========================================================================
  // timing
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real ATOMIC_TIME_MS = 3.4;
  localparam real SPLIT_TIME_MS = 1.8;
  localparam int ATOMIC_CYCLES = int'(ATOMIC_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int SPLIT_CYCLES = int'(SPLIT_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int CNT_W = 20;
  localparam int STALL_W = 3;
  localparam logic [STALL_W-1:0] READ_STALL_CYCLES = 3'h4;
  localparam logic [STALL_W-1:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [STALL_W-1:0] LOAD_STALL_CYCLES = 3'h3;
  localparam logic [STALL_W-1:0] ARM_WINDOW_CYCLES = 3'h4;
  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'b00,
    MODE_ERASE = 2'b01,
    MODE_WRITE = 2'b10,
    MODE_FLUSH = 2'b11
  } mode_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01
  } state_type;
  typedef struct packed {
    logic busy;
    logic page;
    mode_type mode;
    logic rie;
    logic arm;
    logic wstrobe;
  } ctl_type;
  localparam ctl_type CTL_RESET = '{busy: 1'b0, page: 1'b0, mode: MODE_ATOMIC,
                                    rie: 1'b0, arm: 1'b0, wstrobe: 1'b0};
endpackage : nv_eeprom_pkg

// ==== verilog/eeprom_data_access.sv ====
// cpu-side access logic for the 512 byte data eeprom
// assumes the cpu drives select, write and read strobes synchronous to the core clock
`timescale 1ns/100ps
`default_nettype none
module eeprom_data_access
  import nv_eeprom_pkg::*;
#(
  parameter int unsigned P_ATOMIC_CYCLES = ATOMIC_CYCLES,
  parameter int unsigned P_SPLIT_CYCLES = SPLIT_CYCLES
) (
  input wire logic I_CORE_CLK, // core clock
  input wire logic I_RST, // async reset, active high
  input wire logic I_WARM_RST, // sync system reset, keeps a running program
  input wire logic [1:0] I_REG_SEL, // register select
  input wire logic I_REG_WR, // register write strobe
  input wire logic I_REG_RD, // register read strobe
  input wire logic [7:0] I_REG_WDATA, // write data
  output logic [7:0] O_REG_RDATA, // read data, valid cycle after read
  output logic O_CPU_STALL, // halt the cpu
  output logic O_BUSY, // programming in progress
  output logic O_READY_IRQ // ready interrupt request level
);
  // ==========================================================================
  // state
  logic [7:0] mem_q [ARRAY_BYTES];
  logic [7:0] pbuf_q [PAGE_BYTES];
  logic [7:0] pbuf_d [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvalid_q, pvalid_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  ctl_type ctl_q, ctl_d;
  state_type st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [STALL_W-1:0] arm_cnt_q, arm_cnt_d;
  logic [STALL_W-1:0] stall_cnt_q, stall_cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic stall_q, irq_q;
  logic ctl_wr, arm_load, wr_go, rd_go, flush_go, done, load_go;
  mode_type launch_mode;
  logic [PAGE_W-1:0] lsb;

  // resulting cell content for each programming mode
  function automatic logic [7:0] prog_byte(input mode_type m, input logic [7:0] old_b, input logic [7:0] new_b);
    case (m)
      MODE_ATOMIC: prog_byte = new_b;
      MODE_ERASE: prog_byte = ERASED_BYTE;
      MODE_WRITE: prog_byte = old_b & new_b;
      default: prog_byte = old_b;
    endcase
  endfunction : prog_byte

  // ==========================================================================
  // decode
  assign lsb = addr_q[PAGE_W-1:0];
  assign ctl_wr = I_REG_WR && (I_REG_SEL == SEL_CONTROL);
  assign arm_load = ctl_wr && I_REG_WDATA[BIT_ARM];
  // R12 R13 R14 next mode value
  always_comb begin
    launch_mode = ctl_q.mode;
    if (ctl_wr && !ctl_q.wstrobe) begin
      launch_mode = mode_type'(I_REG_WDATA[BIT_MODE_HI:BIT_MODE_LO]);
    end
    if (I_WARM_RST && !ctl_q.busy) begin
      launch_mode = MODE_ATOMIC;
    end
  end
  // R19 armed strobe only
  // R20 strobe counts only inside the arm window
  assign wr_go = ctl_wr && I_REG_WDATA[BIT_WSTROBE] && ctl_q.arm && !ctl_q.wstrobe;
  // R17 flush instead of programming
  assign flush_go = wr_go && (launch_mode == MODE_FLUSH);
  // R22 read strobe, blocked while a write runs
  assign rd_go = ctl_wr && I_REG_WDATA[BIT_RSTROBE] && !ctl_q.wstrobe;
  assign load_go = I_REG_WR && (I_REG_SEL == SEL_DATA) && ctl_q.page;
  // R24 count expiry ends the program
  assign done = (st_q == ST_PROG) && (cnt_q == '0);

  // ==========================================================================
  // address and data registers
  always_comb begin
    addr_d = addr_q;
    data_d = data_q;
    // R04 upper address bits not stored
    if (I_REG_WR && !ctl_q.busy && I_REG_SEL == SEL_ADDR_LOW) begin
      addr_d[7:0] = I_REG_WDATA;
    end
    if (I_REG_WR && !ctl_q.busy && I_REG_SEL == SEL_ADDR_HIGH) begin
      addr_d[8] = I_REG_WDATA[0];
    end
    if (I_REG_WR && I_REG_SEL == SEL_DATA) begin
      data_d = I_REG_WDATA;
    end
    // R07 R22 fetched byte into the data register
    if (rd_go) begin
      data_d = mem_q[addr_q];
    end
    if (I_WARM_RST) begin
      data_d = DATA_RESET;
    end
  end

  // R05 address held at a defined value, software must still load it
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      addr_q <= ADDR_RESET;
      data_q <= DATA_RESET;
    end else begin
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  // ==========================================================================
  // control and status
  always_comb begin
    ctl_d = ctl_q;
    arm_cnt_d = arm_cnt_q;
    st_d = st_q;
    cnt_d = cnt_q;
    // R20 arm window countdown
    if (arm_load) begin
      arm_cnt_d = ARM_WINDOW_CYCLES;
    end else if (arm_cnt_q != '0) begin
      arm_cnt_d = arm_cnt_q - 3'h1;
    end
    ctl_d.arm = (arm_cnt_d != '0);
    if (ctl_wr) begin
      ctl_d.rie = I_REG_WDATA[BIT_RIE];
    end
    // R12 R13 mode field locked while strobe set
    ctl_d.mode = launch_mode;
    // R09 R11 page bit set only while strobe clear
    if (ctl_wr && !ctl_q.wstrobe && I_REG_WDATA[BIT_PAGE]) begin
      ctl_d.page = 1'b1;
    end
    // R08 R15 R16 R24 launch with per-mode count
    if (wr_go && !flush_go) begin
      ctl_d.wstrobe = 1'b1;
      ctl_d.busy = 1'b1;
      st_d = ST_PROG;
      cnt_d = (launch_mode == MODE_ATOMIC) ? CNT_W'(P_ATOMIC_CYCLES - 1) : CNT_W'(P_SPLIT_CYCLES - 1);
    end else if (flush_go) begin
      ctl_d.wstrobe = 1'b1;
    end else if (st_q == ST_PROG && !done) begin
      cnt_d = cnt_q - 20'h00001;
    end
    // R10 flush ends page mode after one strobe cycle
    if (ctl_q.wstrobe && !ctl_q.busy) begin
      ctl_d.wstrobe = 1'b0;
      ctl_d.page = 1'b0;
    end
    // R18 R21 R24 busy, strobe and page clear together
    if (done) begin
      ctl_d.busy = 1'b0;
      ctl_d.wstrobe = 1'b0;
      ctl_d.page = 1'b0;
      st_d = ST_IDLE;
    end
    // R14 warm reset spares a running program
    if (I_WARM_RST) begin
      ctl_d.rie = 1'b0;
      arm_cnt_d = '0;
      ctl_d.arm = 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctl_q <= CTL_RESET;
      arm_cnt_q <= '0;
      st_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      arm_cnt_q <= arm_cnt_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================================
  // temporary page buffer
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_pbuf
      always_comb begin
        pbuf_d[gi] = pbuf_q[gi];
        pvalid_d[gi] = pvalid_q[gi];
        // repeated loads of one byte combine bitwise
        if (load_go && lsb == PAGE_W'(gi)) begin
          pbuf_d[gi] = pvalid_q[gi] ? (pbuf_q[gi] & I_REG_WDATA) : I_REG_WDATA;
          pvalid_d[gi] = 1'b1;
        end
        // R06 single byte write goes through the buffer
        if (wr_go && !flush_go && !ctl_q.page) begin
          pbuf_d[gi] = data_q;
          pvalid_d[gi] = (lsb == PAGE_W'(gi));
        end
        // R17 discard contents
        if (flush_go || done) begin
          pvalid_d[gi] = 1'b0;
        end
      end
      always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
          pbuf_q[gi] <= DATA_RESET;
          pvalid_q[gi] <= 1'b0;
        end else begin
          pbuf_q[gi] <= pbuf_d[gi];
          pvalid_q[gi] <= pvalid_d[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // array, non-volatile so not reset
  // R01 R06 commit loaded bytes at the end of the program time
  always_ff @(posedge I_CORE_CLK) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (done && pvalid_q[i]) begin
        mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <=
          prog_byte(ctl_q.mode, mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}], pbuf_q[i]);
      end
    end
  end

  // ==========================================================================
  // read port, stall and interrupt outputs
  always_comb begin
    rdata_d = rdata_q;
    stall_cnt_d = stall_cnt_q;
    if (I_REG_RD) begin
      case (I_REG_SEL)
        SEL_ADDR_LOW: rdata_d = addr_q[7:0];
        // R04 upper bits read zero
        SEL_ADDR_HIGH: rdata_d = {7'h00, addr_q[8]};
        SEL_DATA: rdata_d = data_q;
        default: rdata_d = {ctl_q.busy, ctl_q.page, ctl_q.mode, ctl_q.rie, ctl_q.arm, ctl_q.wstrobe, 1'b0};
      endcase
    end
    // R02 R03 cpu halt lengths
    if (rd_go) begin
      stall_cnt_d = READ_STALL_CYCLES;
    end else if (wr_go) begin
      stall_cnt_d = WRITE_STALL_CYCLES;
    end else if (load_go) begin
      stall_cnt_d = LOAD_STALL_CYCLES;
    end else if (stall_cnt_q != '0) begin
      stall_cnt_d = stall_cnt_q - 3'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_q <= 8'h00;
      stall_cnt_q <= '0;
      stall_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      stall_cnt_q <= stall_cnt_d;
      stall_q <= (stall_cnt_d != '0);
      // R23 level request while strobe clear
      irq_q <= ctl_d.rie && !ctl_d.wstrobe;
    end
  end

  assign O_REG_RDATA = rdata_q;
  assign O_CPU_STALL = stall_q;
  assign O_BUSY = ctl_q.busy;
  assign O_READY_IRQ = irq_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_quiet4;
    (!rd_go && !wr_go && !load_go) [*4];
  endsequence
  sequence s_stall_end;
    O_CPU_STALL ##1 !O_CPU_STALL;
  endsequence

  chk_read_stall: assert property (rd_go ##1 s_quiet4 |->
    ($past(O_CPU_STALL, 3) && $past(O_CPU_STALL, 2) && $past(O_CPU_STALL)) ##0 s_stall_end) // R02
    else $error("read stall length wrong");
  chk_write_stall: assert property (wr_go ##1 !rd_go && !wr_go && !load_go |-> O_CPU_STALL [*2] ##1 !O_CPU_STALL) // R03
    else $error("write stall length wrong");
  chk_upper_zero: assert property (I_REG_RD && I_REG_SEL == SEL_ADDR_HIGH |=> O_REG_RDATA[7:1] == 7'h00) // R04
    else $error("upper address bits not zero");
  chk_read_data: assert property (rd_go && !I_WARM_RST |=> data_q == $past(mem_q[addr_q])) // R07
    else $error("read data mismatch");
  chk_busy_start: assert property (wr_go && !flush_go |=> O_BUSY && ctl_q.wstrobe) // R08
    else $error("busy not set at program start");
  chk_busy_strobe: assert property (O_BUSY |-> ctl_q.wstrobe && st_q == ST_PROG) // R24
    else $error("busy without strobe");
  chk_flush_clear: assert property (flush_go |=> !O_BUSY ##1 !ctl_q.page && !ctl_q.wstrobe && pvalid_q == '0) // R10
    else $error("flush did not clear page state");
  chk_arm_timeout: assert property ((arm_load && !I_WARM_RST) ##1 (!arm_load && !I_WARM_RST) [*4] |=>
    !ctl_q.arm && $past(ctl_q.arm)) // R20
    else $error("arm bit did not time out");
  chk_mode_lock: assert property (ctl_q.wstrobe && !I_WARM_RST |=> $stable(ctl_q.mode)) // R13
    else $error("mode changed while strobe set");
  chk_done_clear: assert property (done |=> !O_BUSY && !ctl_q.wstrobe && !ctl_q.page) // R21
    else $error("completion did not clear flags");
  chk_irq_level: assert property (O_READY_IRQ == (ctl_q.rie && !ctl_q.wstrobe)) // R23
    else $error("ready interrupt level wrong");
  chk_prog_count: assert property (wr_go && launch_mode == MODE_ERASE |=> cnt_q == CNT_W'(P_SPLIT_CYCLES - 1)) // R16
    else $error("split program count wrong");
endmodule : eeprom_data_access
`default_nettype wire

// ==== sim/test_eeprom_data_access.sv ====
// self-checking bench for the data eeprom access block
// assumes the package and the design module are compiled first; short program counts
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_data_access
  import nv_eeprom_pkg::*;
;
  // ==========================================================================
  // stimulus and design
  localparam int unsigned AT = 20;
  localparam int unsigned SP = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic warm = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] v;
  wire logic [7:0] rdata;
  wire logic stall;
  wire logic busy;
  wire logic irq;
  int bad_count = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  eeprom_data_access #(.P_ATOMIC_CYCLES(AT), .P_SPLIT_CYCLES(SP)) u_dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_WARM_RST(warm), .I_REG_SEL(sel), .I_REG_WR(wr),
    .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_CPU_STALL(stall),
    .O_BUSY(busy), .O_READY_IRQ(irq)
  );

  // ==========================================================================
  // shared tasks
  task automatic tally_and_finish;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    #1;
    sel = s;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] s, output logic [7:0] d);
    @(posedge clk);
    #1;
    sel = s;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg

  task automatic stall_len(input int exp);
    int n;
    n = 0;
    while (stall === 1'b1 && n < 10) begin
      n++;
      @(posedge clk);
      #1;
    end
    check(n, exp);
  endtask : stall_len

  task automatic rd_byte(input logic [8:0] a, input logic [7:0] exp);
    wr_reg(SEL_ADDR_LOW, a[7:0]);
    wr_reg(SEL_ADDR_HIGH, {7'h00, a[8]});
    wr_reg(SEL_CONTROL, 8'h01);
    stall_len(4);
    rd_reg(SEL_DATA, v);
    check(v, exp);
  endtask : rd_byte

  // ==========================================================================
  // scenarios
  // timed program
  task automatic prog(input mode_type m, input logic [8:0] a, input logic [7:0] d, input int gap,
                      input logic wm, input int cycles, input logic [7:0] exp);
    int n;
    int s;
    wr_reg(SEL_ADDR_LOW, a[7:0]);
    wr_reg(SEL_ADDR_HIGH, {7'h00, a[8]});
    wr_reg(SEL_DATA, d);
    wr_reg(SEL_CONTROL, {2'b00, m, 4'b1100});
    repeat (gap) @(posedge clk);
    wr_reg(SEL_CONTROL, {2'b00, m, 4'b1110});
    check(irq, 1'b0);
    n = 0;
    s = 0;
    while (busy === 1'b1 && n < 100) begin
      if (stall === 1'b1) s++;
      if (n == 5) begin
        sel = SEL_CONTROL;
        wdata = {2'b01, ~m, 4'b1000};
        wr = 1'b1;
      end
      if (n == 6) begin
        wr = 1'b0;
        warm = wm;
      end
      if (n == 7) warm = 1'b0;
      n++;
      @(posedge clk);
      #1;
    end
    check(n, cycles);
    check(s, 2);
    check(irq, !wm);
    rd_reg(SEL_CONTROL, v);
    check(v, {2'b00, m, !wm, 3'b000});
    rd_byte(a, exp);
  endtask : prog

  task automatic refused;
    wr_reg(SEL_CONTROL, 8'h02);
    check(busy, 1'b0);
    wr_reg(SEL_CONTROL, 8'h04);
    rd_reg(SEL_CONTROL, v);
    check(v, 8'h04);
    @(posedge clk);
    wr_reg(SEL_CONTROL, 8'h02);
    check(busy, 1'b0);
    rd_reg(SEL_CONTROL, v);
    check(v, 8'h00);
    wr_reg(SEL_CONTROL, 8'h28);
    @(posedge clk);
    #1;
    warm = 1'b1;
    @(posedge clk);
    #1;
    warm = 1'b0;
    rd_reg(SEL_CONTROL, v);
    check(v, 8'h00);
  endtask : refused

  task automatic flush;
    wr_reg(SEL_CONTROL, 8'h40);
    rd_reg(SEL_CONTROL, v);
    check(v, 8'h40);
    wr_reg(SEL_ADDR_LOW, 8'h21);
    wr_reg(SEL_DATA, 8'h99);
    stall_len(3);
    wr_reg(SEL_CONTROL, 8'h74);
    wr_reg(SEL_CONTROL, 8'h76);
    check(busy, 1'b0);
    stall_len(2);
    repeat (2) @(posedge clk);
    rd_reg(SEL_CONTROL, v);
    check(v, 8'h30);
  endtask : flush

  // page program commits every loaded slot
  task automatic page;
    wr_reg(SEL_CONTROL, 8'h40);
    wr_reg(SEL_ADDR_HIGH, 8'h01);
    wr_reg(SEL_ADDR_LOW, 8'hf0);
    wr_reg(SEL_DATA, 8'hc3);
    wr_reg(SEL_ADDR_LOW, 8'hf1);
    wr_reg(SEL_DATA, 8'h5a);
    wr_reg(SEL_CONTROL, 8'h44);
    wr_reg(SEL_CONTROL, 8'h46);
    check(busy, 1'b1);
    repeat (AT + 4) @(posedge clk);
    #1;
    check(busy, 1'b0);
    rd_reg(SEL_CONTROL, v);
    check(v, 8'h00);
    rd_byte(9'h1f0, 8'hc3);
    rd_byte(9'h1f1, 8'h5a);
  endtask : page

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    check({stall, busy, irq}, 3'b000);
    rd_reg(SEL_CONTROL, v);
    check(v, 8'h00);
    rd_reg(SEL_DATA, v);
    check(v, DATA_RESET);
    wr_reg(SEL_ADDR_HIGH, 8'hff);
    rd_reg(SEL_ADDR_HIGH, v);
    check(v, 8'h01);
    prog(MODE_ATOMIC, 9'h15a, 8'h3c, 0, 1'b0, AT, 8'h3c);
    prog(MODE_ERASE, 9'h15a, 8'h00, 2, 1'b1, SP, ERASED_BYTE);
    prog(MODE_WRITE, 9'h15a, 8'ha5, 0, 1'b0, SP, 8'ha5);
    prog(MODE_WRITE, 9'h15a, 8'h0f, 0, 1'b0, SP, 8'h05);
    prog(MODE_ATOMIC, 9'h000, 8'h77, 0, 1'b0, AT, 8'h77);
    refused();
    flush();
    page();
    tally_and_finish();
  end

  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : test_eeprom_data_access
`default_nettype wire
